// ==== rtl/pcg1_pkg.sv ====
// constants for peripheral clock gating group 1
`default_nettype none
package pcg1_pkg;
	// ==================================================
	// register offsets (byte addresses in system-control space)
	localparam logic [31:0] PCG_SYSCTL_BASE = 32'h400F_E000;
	localparam logic [11:0] PCG_OFS_RUN_CFG = 12'h060;
	localparam logic [11:0] PCG_OFS_RUN_GATE = 12'h104;
	localparam logic [11:0] PCG_OFS_SLEEP_GATE = 12'h114;
	localparam logic [11:0] PCG_OFS_DEEP_GATE = 12'h124;
	localparam logic [11:0] PCG_OFS_STATUS = 12'h130;

	// ==================================================
	// gating field positions
	localparam int PCG_NUNITS = 7;
	localparam int PCG_ASYNC0_BIT = 0;
	localparam int PCG_ASYNC1_BIT = 1;
	localparam int PCG_SYNC0_BIT = 4;
	localparam int PCG_TWOWIRE0_BIT = 12;
	localparam int PCG_COUNTER0_BIT = 16;
	localparam int PCG_COUNTER1_BIT = 17;
	localparam int PCG_COUNTER2_BIT = 18;
	// unit index to bit position, unit 0 first
	localparam int PCG_POS [PCG_NUNITS] = '{PCG_ASYNC0_BIT, PCG_ASYNC1_BIT,
		PCG_SYNC0_BIT, PCG_TWOWIRE0_BIT, PCG_COUNTER0_BIT, PCG_COUNTER1_BIT,
		PCG_COUNTER2_BIT};
	// writable bits of a gating register
	localparam logic [31:0] PCG_GATE_MASK = 32'h0007_1013;
	localparam logic [31:0] PCG_GATE_RESET = 32'h0000_0000;

	// ==================================================
	// run clock configuration and status fields
	localparam int PCG_AUTO_GATE_BIT = 27;
	localparam logic PCG_AUTO_GATE_RESET = 1'b0;
	localparam int PCG_STAT_MODE_LSB = 8;

	// ==================================================
	// power modes
	typedef enum logic [2:0]
	{
		PCG_MODE_RUN = 3'b001,
		PCG_MODE_SLEEP = 3'b010,
		PCG_MODE_DEEP = 3'b100
	} pcg_mode_t;
endpackage
`default_nettype wire

// ==== rtl/pcg1_gate.sv ====
// clock gating control for one group of peripheral units
`timescale 1ns/10ps
`default_nettype none

module pcg1_gate
	import pcg1_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// power mode requests from power control
	input wire logic sleep_mode,
	input wire logic deepsleep_mode,
	// peripheral access monitor from system bus decode
	input wire logic periph_access,
	input wire logic [6:0] periph_sel,
	output logic bus_fault,
	// gated unit clocks and enables
	output logic [6:0] unit_clk,
	output logic [6:0] unit_en
);

	// ==================================================
	// helpers
	function automatic logic [31:0] pcg_pack(input logic [PCG_NUNITS-1:0] v);
		logic [31:0] w;
		w = 32'h0000_0000;
		for (int i = 0; i < PCG_NUNITS; i++)
		begin
			w[PCG_POS[i]] = v[i];
		end
		return w;
	endfunction

	function automatic logic [PCG_NUNITS-1:0] pcg_unpack(input logic [31:0] w);
		logic [PCG_NUNITS-1:0] v;
		v = '0;
		for (int i = 0; i < PCG_NUNITS; i++)
		begin
			v[i] = w[PCG_POS[i]];
		end
		return v;
	endfunction

	// ==================================================
	// registers
	logic [PCG_NUNITS-1:0] run_gate_r;
	logic [PCG_NUNITS-1:0] sleep_gate_r;
	logic [PCG_NUNITS-1:0] deep_gate_r;
	logic auto_gate_r;
	pcg_mode_t mode_r;
	pcg_mode_t mode_nxt;
	logic [PCG_NUNITS-1:0] unit_en_r;
	logic bus_fault_r;
	logic [31:0] prdata_r;

	// ==================================================
	// bus decode
	wire setup_ph = psel & ~penable;
	wire access_ph = psel & penable;
	wire hit_cfg = (paddr == PCG_OFS_RUN_CFG);
	wire hit_run = (paddr == PCG_OFS_RUN_GATE);
	wire hit_sleep = (paddr == PCG_OFS_SLEEP_GATE);
	wire hit_deep = (paddr == PCG_OFS_DEEP_GATE);
	wire hit_stat = (paddr == PCG_OFS_STATUS);
	wire hit_any = hit_cfg | hit_run | hit_sleep | hit_deep | hit_stat;
	wire wr_take = access_ph & pwrite & hit_any;
	wire [PCG_NUNITS-1:0] wr_gate = pcg_unpack(pwdata & PCG_GATE_MASK);

	wire [31:0] cfg_word = {4'h0, auto_gate_r, 27'h000_0000};
	wire [31:0] stat_word = pcg_pack(unit_en_r) | {21'h00_0000, mode_r, 8'h00};
	// reserved bits come back zero by construction
	wire [31:0] rd_word = hit_cfg ? cfg_word :
		hit_run ? pcg_pack(run_gate_r) :
		hit_sleep ? pcg_pack(sleep_gate_r) :
		hit_deep ? pcg_pack(deep_gate_r) :
		hit_stat ? stat_word : 32'h0000_0000;

	assign pready = 1'b1;
	assign pslverr = access_ph & ~hit_any;
	assign prdata = prdata_r;

	// ==================================================
	// mode selection
	always_comb
	begin
		if (deepsleep_mode)
			mode_nxt = PCG_MODE_DEEP;
		else if (sleep_mode)
			mode_nxt = PCG_MODE_SLEEP;
		else
			mode_nxt = PCG_MODE_RUN;
	end

	logic [PCG_NUNITS-1:0] active_gate;
	always_comb
	begin
		case (mode_r)
			PCG_MODE_RUN: active_gate = run_gate_r;
			PCG_MODE_SLEEP: active_gate = auto_gate_r ? sleep_gate_r : run_gate_r;
			PCG_MODE_DEEP: active_gate = auto_gate_r ? deep_gate_r : run_gate_r;
			default: active_gate = run_gate_r;
		endcase
	end

	wire fault_nxt = periph_access & |(periph_sel & ~unit_en_r);

	// ==================================================
	// register updates
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_gate_r <= '0;
			sleep_gate_r <= '0;
			deep_gate_r <= '0;
			auto_gate_r <= PCG_AUTO_GATE_RESET;
		end
		else if (wr_take)
		begin
			if (hit_run)
				run_gate_r <= wr_gate;
			if (hit_sleep)
				sleep_gate_r <= wr_gate;
			if (hit_deep)
				deep_gate_r <= wr_gate;
			if (hit_cfg)
				auto_gate_r <= pwdata[PCG_AUTO_GATE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_r <= PCG_MODE_RUN;
			unit_en_r <= '0;
			bus_fault_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			mode_r <= mode_nxt;
			unit_en_r <= active_gate;
			bus_fault_r <= fault_nxt;
			if (setup_ph & ~pwrite)
				prdata_r <= rd_word;
		end
	end

	assign unit_en = unit_en_r;
	assign bus_fault = bus_fault_r;

	// ==================================================
	// glitch-free clock gates
	for (genvar g = 0; g < PCG_NUNITS; g++)
	begin : g_gate
		logic gate_lat;
		// enable only changes while pclk is low
		always_latch
		begin
			if (!presetn)
				gate_lat = 1'b0;
			else if (!pclk)
				gate_lat = unit_en_r[g];
		end
		assign unit_clk[g] = pclk & gate_lat;
	end

	// ==================================================
	// assertions
	wire wr_done = access_ph & pwrite;
	wire [31:0] run_word = pcg_pack(run_gate_r);
	wire [31:0] deep_word = pcg_pack(deep_gate_r);

	AST_RESET_ZERO: assert property (@(posedge pclk)
		$rose(presetn) |-> (sleep_gate_r == '0 && run_gate_r == '0 && unit_en_r == '0))
		else $error("gating state not zero after reset");

	AST_SLEEP_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_done && paddr == PCG_OFS_SLEEP_GATE
		|=> pcg_pack(sleep_gate_r) == ($past(pwdata) & PCG_GATE_MASK))
		else $error("sleep gating write not stored");

	AST_RUN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_done && paddr == PCG_OFS_RUN_GATE
		|=> pcg_pack(run_gate_r) == ($past(pwdata) & PCG_GATE_MASK))
		else $error("run gating write not stored");

	AST_DEEP_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_done && paddr == PCG_OFS_DEEP_GATE
		|=> pcg_pack(deep_gate_r) == ($past(pwdata) & PCG_GATE_MASK))
		else $error("deep-sleep gating write not stored");

	AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		access_ph && !pwrite && (hit_run || hit_sleep || hit_deep)
		|-> (prdata & ~PCG_GATE_MASK) == 32'h0000_0000)
		else $error("reserved bits read nonzero");

	AST_COUNTER_BITS: assert property (@(posedge pclk) disable iff (!presetn)
		mode_r == PCG_MODE_RUN
		|=> unit_en[6:4] == $past(run_word[PCG_COUNTER2_BIT:PCG_COUNTER0_BIT]))
		else $error("counter enables do not follow bits 18..16");

	AST_SERIAL_READ: assert property (@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && hit_sleep ##1 access_ph
		|-> prdata[PCG_TWOWIRE0_BIT] == sleep_gate_r[3] && prdata[PCG_SYNC0_BIT] == sleep_gate_r[2]
		&& prdata[1:0] == sleep_gate_r[1:0])
		else $error("serial gating bits read back wrong");

	AST_RUN_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
		mode_r == PCG_MODE_RUN |=> unit_en_r == $past(run_gate_r))
		else $error("run mode does not apply run register");

	AST_AUTO_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
		mode_r == PCG_MODE_SLEEP && auto_gate_r |=> unit_en_r == $past(sleep_gate_r))
		else $error("sleep register not applied under auto gating");

	AST_NO_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
		mode_r != PCG_MODE_RUN && !auto_gate_r |=> unit_en_r == $past(run_gate_r))
		else $error("sleep register applied without auto gating");

	AST_FAULT_RAISE: assert property (@(posedge pclk) disable iff (!presetn)
		periph_access && (periph_sel & ~unit_en) != '0 |=> bus_fault)
		else $error("access to stopped unit raised no fault");

	AST_FAULT_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		!periph_access || (periph_sel & ~unit_en) == '0 |=> !bus_fault)
		else $error("fault without access to stopped unit");

	// sampled at the falling edge, so the high phase just ended is seen
	AST_CLK_OFF: assert property (@(negedge pclk) disable iff (!presetn)
		!unit_en[0] && !$past(unit_en[0]) |-> !unit_clk[0])
		else $error("stopped unit still clocked");

	AST_CLK_ON: assert property (@(negedge pclk) disable iff (!presetn)
		unit_en[6] && $past(unit_en[6]) |-> unit_clk[6])
		else $error("enabled unit not clocked");

	AST_DEEP_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
		mode_r == PCG_MODE_DEEP && auto_gate_r
		|=> unit_en_r == $past(deep_gate_r))
		else $error("deep-sleep register not applied under auto gating");

	AST_MODE_DEEP: assert property (@(posedge pclk) disable iff (!presetn)
		deepsleep_mode
		|=> mode_r == PCG_MODE_DEEP)
		else $error("deep-sleep request not taken");

	AST_MODE_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_mode && !deepsleep_mode
		|=> mode_r == PCG_MODE_SLEEP)
		else $error("sleep request not taken");

	AST_MODE_RUN: assert property (@(posedge pclk) disable iff (!presetn)
		!sleep_mode && !deepsleep_mode
		|=> mode_r == PCG_MODE_RUN)
		else $error("run mode not restored");

	// ==================================================
	// register bus assertions

	AST_CFG_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_done && hit_cfg
		|=> auto_gate_r == $past(pwdata[PCG_AUTO_GATE_BIT]))
		else $error("auto gate select write not stored");

	AST_CFG_READ: assert property (@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && hit_cfg
		|=> prdata == {4'h0, $past(auto_gate_r), 27'h000_0000})
		else $error("clock configuration read back wrong");

	AST_RUN_READ: assert property (@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && hit_run
		|=> prdata == $past(run_word))
		else $error("run gating read back wrong");

	AST_DEEP_READ: assert property (@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && hit_deep
		|=> prdata == $past(deep_word))
		else $error("deep-sleep gating read back wrong");

	AST_STAT_READ: assert property (@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && hit_stat
		|=> prdata == $past(stat_word))
		else $error("status read back wrong");

	AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
		access_ph && !pwrite && !hit_any
		|-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped read not refused");

	AST_UNMAPPED_NOWRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_done && !hit_any
		|=> $stable(run_gate_r) && $stable(sleep_gate_r) && $stable(deep_gate_r))
		else $error("unmapped write changed a gating register");

	AST_STATUS_NOWRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_done && hit_stat
		|=> $stable(run_gate_r) && $stable(sleep_gate_r) && $stable(auto_gate_r))
		else $error("status write changed a register");

	AST_READ_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!(setup_ph && !pwrite)
		|=> $stable(prdata))
		else $error("read data changed outside a read setup");

	COV_SLEEP_AUTO: cover property (@(posedge pclk) disable iff (!presetn)
		mode_r == PCG_MODE_SLEEP && auto_gate_r && sleep_gate_r != '0);
	COV_DEEP_AUTO: cover property (@(posedge pclk) disable iff (!presetn)
		mode_r == PCG_MODE_DEEP && auto_gate_r && deep_gate_r != '0);
	COV_FAULT: cover property (@(posedge pclk) disable iff (!presetn) bus_fault);
	COV_UNMAPPED: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
	COV_RUN_ON: cover property (@(posedge pclk) disable iff (!presetn)
		mode_r == PCG_MODE_RUN && unit_en_r != '0);

endmodule
`default_nettype wire

// ==== sim/pcg1_unit_model.sv ====
// behavioural model of the gated units' clock inputs
`timescale 1ns/10ps
`default_nettype none
module pcg1_unit_model
(
	// gated clocks from the block
	input wire logic [6:0] unit_clk,
	// bench control and observation
	input wire logic clr,
	output logic [6:0] ticked,
	output logic [6:0] glitch
);
	initial glitch = '0;
	for (genvar i = 0; i < 7; i++)
	begin : g_unit
		// far in the past so the power-up edge is not taken for a glitch
		realtime t_rise = -100.0;
		// a unit only ticks while its clock runs
		always @(posedge unit_clk[i] or posedge clr)
			if (clr)
				ticked[i] <= 1'b0;
			else
			begin
				ticked[i] <= 1'b1;
				t_rise = $realtime;
			end
		// high phase shorter than 1.9 ns, just under half the 4 ns period, is a glitch
		always @(negedge unit_clk[i])
			if ($realtime - t_rise < 1.9)
				glitch[i] <= 1'b1;
	end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for peripheral clock gating group 1
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
	$display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb import pcg1_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, sleep_mode, deepsleep_mode;
	logic periph_access, clr, pready, pslverr, bus_fault, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0] periph_sel, unit_clk, unit_en, ticked, glitch;
	int fails = 0;
	int checks_done = 0;
	pcg1_gate pcg1_gate_inst(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sleep_mode, .deepsleep_mode,
		.periph_access, .periph_sel, .bus_fault, .unit_clk, .unit_en);
	pcg1_unit_model pcg1_unit_model_inst(.unit_clk, .clr, .ticked, .glitch);
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic results();
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==================================================
	// bus and observation helpers
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			fails++;
			results();
		end
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rd, e)
		`CHK(err, 1'b0)
	endtask
	task automatic en_is(input logic [6:0] e);
		repeat (3) @(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (4) @(posedge pclk);
		#1;
		`CHK(unit_en, e)
		`CHK(ticked, e)
	endtask
	task automatic fault(input logic [6:0] s, input logic e);
		@(posedge pclk);
		periph_access <= 1'b1;
		periph_sel <= s;
		@(posedge pclk);
		periph_access <= 1'b0;
		#1;
		`CHK(bus_fault, e)
		@(posedge pclk);
		#1;
		`CHK(bus_fault, 1'b0)
	endtask
	// ==================================================
	// scenarios
	task automatic t_reset();
		rdchk(12'h104, 32'h0000_0000);
		rdchk(12'h114, 32'h0000_0000);
		rdchk(12'h124, 32'h0000_0000);
		rdchk(PCG_OFS_RUN_CFG, 32'h0000_0000);
		en_is(7'h00);
		fault(7'h40, 1'b1);
	endtask
	task automatic t_regs();
		apb(1'b1, 12'h114, 32'hFFFF_FFFF);
		rdchk(12'h114, 32'h0007_1013);
		apb(1'b1, 12'h124, 32'hFFFF_FFFF);
		rdchk(12'h124, 32'h0007_1013);
		en_is(7'h00);
	endtask
	task automatic t_units();
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b1, 12'h104, 32'h1 << PCG_POS[i]);
			rdchk(12'h104, 32'h1 << PCG_POS[i]);
			en_is(7'h01 << i);
			fault(7'h01 << i, 1'b0);
			fault(7'h01 << ((i + 1) % 7), 1'b1);
		end
	endtask
	task automatic t_modes();
		apb(1'b1, 12'h104, 32'h0000_0013);
		apb(1'b1, 12'h114, 32'h0000_1000);
		apb(1'b1, 12'h124, 32'h0007_0000);
		sleep_mode <= 1'b1;
		en_is(7'h07);
		apb(1'b0, PCG_OFS_RUN_CFG, 32'h0000_0000);
		apb(1'b1, PCG_OFS_RUN_CFG, rd | 32'h0800_0000);
		rdchk(PCG_OFS_RUN_CFG, 32'h0800_0000);
		en_is(7'h08);
		fault(7'h01, 1'b1);
		@(posedge pclk);
		deepsleep_mode <= 1'b1;
		en_is(7'h70);
		apb(1'b1, PCG_OFS_STATUS, 32'hFFFF_FFFF);
		`CHK(err, 1'b0)
		rdchk(PCG_OFS_STATUS, 32'h0007_0400);
		@(posedge pclk);
		sleep_mode <= 1'b0;
		deepsleep_mode <= 1'b0;
		en_is(7'h07);
	endtask
	task automatic t_unmapped();
		apb(1'b1, 12'h200, 32'hFFFF_FFFF);
		`CHK(err, 1'b1)
		apb(1'b0, 12'h200, 32'h0000_0000);
		`CHK(err, 1'b1)
		rdchk(12'h114, 32'h0000_1000);
		`CHK(glitch, 7'h00)
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, sleep_mode, deepsleep_mode} = '0;
		{periph_access, periph_sel, paddr, pwdata} = '0;
		clr = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		clr <= 1'b0;
		t_reset();
		t_regs();
		t_units();
		t_modes();
		t_unmapped();
		results();
	end
endmodule
`default_nettype wire
